// file: rtl/acc_pkg.sv
package acc_pkg;

	localparam logic [7:0] ACC_CLOCK_ROLE_OFFSET = 8'h0D;
	localparam logic [7:0] ACC_ADC_CHANNEL_OFFSET = 8'h0E;
	localparam logic [7:0] ACC_DAC_CHANNEL_OFFSET = 8'h0F;
	localparam logic [7:0] ACC_RATE_ENABLE_OFFSET = 8'h17;
	localparam logic [7:0] ACC_RATE_RATIO_OFFSET = 8'h18;

	localparam logic [7:0] ACC_REG_RESET = 8'h00;

	// Writable bits; the rest read as zero
	localparam logic [7:0] ACC_CLOCK_ROLE_WMASK = 8'hDF;
	localparam logic [7:0] ACC_CHANNEL_WMASK = 8'hF8;
	localparam logic [7:0] ACC_RATE_ENABLE_WMASK = 8'hC0;
	localparam logic [7:0] ACC_RATE_RATIO_WMASK = 8'hFF;

	localparam int ACC_PRIMARY_OVERRIDE_BIT = 7;
	localparam int ACC_SECONDARY_OVERRIDE_BIT = 6;
	localparam int ACC_PRIMARY_INT_FS_BIT = 2;
	localparam int ACC_SECONDARY_INT_FS_BIT = 1;
	localparam int ACC_FORCE_CUSTOM_BIT = 7;
	localparam int ACC_CUSTOM_MASK_LSB = 3;
	localparam int ACC_RATE_ENABLE_BIT = 7;
	localparam int ACC_AUTODETECT_DIS_BIT = 6;
	localparam int ACC_MAIN_MANUAL_BIT = 7;
	localparam int ACC_MAIN_SELECT_BIT = 6;
	localparam int ACC_RATIO_M_LSB = 3;
	localparam int ACC_RATIO_N_LSB = 0;

	localparam logic [2:0] ACC_RATIO_AUTO = 3'h0;
	localparam logic [2:0] ACC_RATIO_RSVD_A = 3'h5;
	localparam logic [2:0] ACC_RATIO_RSVD_B = 3'h7;

	typedef struct packed {
		logic bit_clock_output;
		logic frame_sync_output;
		logic autodetect_available;
		logic internal_frame_sync;
	} acc_port_type;

	typedef struct packed {
		logic auto_infer;
		logic reserved;
		logic [2:0] value;
	} acc_ratio_type;

	typedef struct packed {
		logic rate_converter_enable;
		logic autodetect_active;
		logic main_rate_auto;
		logic main_rate_from_secondary;
		acc_ratio_type ratio_m;
		acc_ratio_type ratio_n;
	} acc_rate_type;

	localparam acc_port_type ACC_PORT_RESET = '0;
	localparam acc_rate_type ACC_RATE_RESET = '0;
	localparam logic [3:0] ACC_MASK_RESET = 4'h0;

endpackage : acc_pkg

// file: rtl/acc_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Primary override bit 7 off means roles follow primary role select.
// - Secondary override bit 6 does the same for the secondary port.
// - An overridden port reports clock auto detection as unavailable.
// - Override with role 0: clock in, sync out; role 1: reverse.
// - Bit 2 picks internal or external frame sync for primary controller.
// - Bit 1 picks internal or external frame sync for secondary controller.
// - ADC force bit chooses custom mask over the max channel selection.
// - ADC custom mask bits 6-3 enable channels four down to one.
// - DAC force bit chooses custom mask over the max channel selection.
// - DAC custom mask bits 6-3 enable channels four down to one.
// - Rate converter enable bit 7 turns the converter on or off.
// - Bit 6 set disables rate converter auto detection.
// - Main rate manual bit 7 off means the main rate is inferred.
// - Main rate select 0 takes primary rate, 1 takes secondary rate.
// - Ratio m code 0 is automatic, 1-4 and 6 direct, 5 and 7 reserved.
// - Ratio n code 0 is automatic, 1-4 and 6 direct, 5 and 7 reserved.
module acc_config_regs
	import acc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_address,
	input wire logic [7:0] reg_write_data,
	output logic [7:0] reg_read_data,
	output logic reg_read_valid,
	input wire logic primary_role_select,
	input wire logic secondary_role_select,
	input wire logic [3:0] adc_max_channel_select,
	input wire logic [3:0] dac_max_channel_select,
	output acc_port_type primary_port_cfg,
	output acc_port_type secondary_port_cfg,
	output logic [3:0] adc_channel_enable,
	output logic [3:0] dac_channel_enable,
	output acc_rate_type rate_cfg
);

	logic [7:0] clock_role_reg;
	logic [7:0] adc_channel_reg;
	logic [7:0] dac_channel_reg;
	logic [7:0] rate_enable_reg;
	logic [7:0] rate_ratio_reg;
	logic [7:0] read_data_reg;
	logic [7:0] read_data_next;
	logic read_valid_reg;
	acc_port_type primary_reg;
	acc_port_type secondary_reg;
	logic [3:0] adc_enable_reg;
	logic [3:0] dac_enable_reg;
	acc_rate_type rate_reg;

	function automatic acc_port_type port_decode(
		input logic override_bit,
		input logic role_bit,
		input logic internal_bit
	);
		acc_port_type result;
		if (override_bit)
		begin
			result.bit_clock_output = role_bit;
			result.frame_sync_output = ~role_bit;
			result.autodetect_available = 1'b0;
		end
		else
		begin
			result.bit_clock_output = role_bit;
			result.frame_sync_output = role_bit;
			result.autodetect_available = 1'b1;
		end
		result.internal_frame_sync = result.frame_sync_output & internal_bit;
		return result;
	endfunction : port_decode

	function automatic acc_ratio_type ratio_decode(input logic [2:0] code);
		acc_ratio_type result;
		result.auto_infer = (code == ACC_RATIO_AUTO);
		result.reserved = (code == ACC_RATIO_RSVD_A) ||
			(code == ACC_RATIO_RSVD_B);
		result.value = result.reserved ? ACC_RATIO_AUTO : code;
		return result;
	endfunction : ratio_decode

	function automatic logic [3:0] channel_select(input logic [7:0] cfg,
		input logic [3:0] standard);
		return cfg[ACC_FORCE_CUSTOM_BIT] ?
			cfg[ACC_CUSTOM_MASK_LSB +: 4] : standard;
	endfunction : channel_select

	// Register writes; read-only bits stay zero
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			clock_role_reg <= ACC_REG_RESET;
			adc_channel_reg <= ACC_REG_RESET;
			dac_channel_reg <= ACC_REG_RESET;
			rate_enable_reg <= ACC_REG_RESET;
			rate_ratio_reg <= ACC_REG_RESET;
		end
		else if (reg_write)
		begin
			unique case (reg_address)
				ACC_CLOCK_ROLE_OFFSET:
					clock_role_reg <= reg_write_data & ACC_CLOCK_ROLE_WMASK;
				ACC_ADC_CHANNEL_OFFSET:
					adc_channel_reg <= reg_write_data & ACC_CHANNEL_WMASK;
				ACC_DAC_CHANNEL_OFFSET:
					dac_channel_reg <= reg_write_data & ACC_CHANNEL_WMASK;
				ACC_RATE_ENABLE_OFFSET:
					rate_enable_reg <= reg_write_data & ACC_RATE_ENABLE_WMASK;
				ACC_RATE_RATIO_OFFSET:
					rate_ratio_reg <= reg_write_data & ACC_RATE_RATIO_WMASK;
				default:
				begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		unique case (reg_address)
			ACC_CLOCK_ROLE_OFFSET: read_data_next = clock_role_reg;
			ACC_ADC_CHANNEL_OFFSET: read_data_next = adc_channel_reg;
			ACC_DAC_CHANNEL_OFFSET: read_data_next = dac_channel_reg;
			ACC_RATE_ENABLE_OFFSET: read_data_next = rate_enable_reg;
			ACC_RATE_RATIO_OFFSET: read_data_next = rate_ratio_reg;
			default: read_data_next = ACC_REG_RESET;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			read_data_reg <= ACC_REG_RESET;
			read_valid_reg <= 1'b0;
		end
		else
		begin
			read_valid_reg <= reg_read;
			if (reg_read)
				read_data_reg <= read_data_next;
		end
	end

	// Serial port clock roles
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			primary_reg <= ACC_PORT_RESET;
			secondary_reg <= ACC_PORT_RESET;
		end
		else
		begin
			primary_reg <= port_decode(
				clock_role_reg[ACC_PRIMARY_OVERRIDE_BIT],
				primary_role_select,
				clock_role_reg[ACC_PRIMARY_INT_FS_BIT]);
			secondary_reg <= port_decode(
				clock_role_reg[ACC_SECONDARY_OVERRIDE_BIT],
				secondary_role_select,
				clock_role_reg[ACC_SECONDARY_INT_FS_BIT]);
		end
	end

	// Dynamic mode channel limits
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			adc_enable_reg <= ACC_MASK_RESET;
			dac_enable_reg <= ACC_MASK_RESET;
		end
		else
		begin
			adc_enable_reg <= channel_select(adc_channel_reg,
				adc_max_channel_select);
			dac_enable_reg <= channel_select(dac_channel_reg,
				dac_max_channel_select);
		end
	end

	// Rate converter settings
	always_ff @(posedge clock)
	begin
		if (reset)
			rate_reg <= ACC_RATE_RESET;
		else
		begin
			rate_reg.rate_converter_enable <=
				rate_enable_reg[ACC_RATE_ENABLE_BIT];
			rate_reg.autodetect_active <=
				~rate_enable_reg[ACC_AUTODETECT_DIS_BIT];
			rate_reg.main_rate_auto <=
				~rate_ratio_reg[ACC_MAIN_MANUAL_BIT];
			rate_reg.main_rate_from_secondary <=
				rate_ratio_reg[ACC_MAIN_MANUAL_BIT] &
				rate_ratio_reg[ACC_MAIN_SELECT_BIT];
			rate_reg.ratio_m <=
				ratio_decode(rate_ratio_reg[ACC_RATIO_M_LSB +: 3]);
			rate_reg.ratio_n <=
				ratio_decode(rate_ratio_reg[ACC_RATIO_N_LSB +: 3]);
		end
	end

	assign reg_read_data = read_data_reg;
	assign reg_read_valid = read_valid_reg;
	assign primary_port_cfg = primary_reg;
	assign secondary_port_cfg = secondary_reg;
	assign adc_channel_enable = adc_enable_reg;
	assign dac_channel_enable = dac_enable_reg;
	assign rate_cfg = rate_reg;

	// Checks
	logic past_valid_reg;

	always_ff @(posedge clock)
	begin
		if (reset)
			past_valid_reg <= 1'b0;
		else
			past_valid_reg <= 1'b1;
	end

	sequence s_primary_override_write(logic role);
		reg_write && reg_address == ACC_CLOCK_ROLE_OFFSET &&
			reg_write_data[ACC_PRIMARY_OVERRIDE_BIT] ##1
			primary_role_select == role;
	endsequence

	property p_primary_standard;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		!$past(clock_role_reg[ACC_PRIMARY_OVERRIDE_BIT]) |->
			primary_port_cfg.bit_clock_output == $past(primary_role_select) &&
			primary_port_cfg.frame_sync_output == $past(primary_role_select);
	endproperty
	a_primary_standard: assert property (p_primary_standard)
		else $error("primary role not following role select");

	property p_secondary_override;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		$past(clock_role_reg[ACC_SECONDARY_OVERRIDE_BIT]) |->
			secondary_port_cfg.bit_clock_output ==
				$past(secondary_role_select) &&
			secondary_port_cfg.frame_sync_output ==
				!$past(secondary_role_select);
	endproperty
	a_secondary_override: assert property (p_secondary_override)
		else $error("secondary override roles wrong");

	property p_autodetect_blocked;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		primary_port_cfg.autodetect_available ==
			!$past(clock_role_reg[ACC_PRIMARY_OVERRIDE_BIT]);
	endproperty
	a_autodetect_blocked: assert property (p_autodetect_blocked)
		else $error("auto detect available under override");

	property p_primary_override_roles;
		@(posedge clock) disable iff (reset)
		s_primary_override_write(1'b0) ##1
			primary_role_select == 1'b0 |=>
			!primary_port_cfg.bit_clock_output &&
			primary_port_cfg.frame_sync_output;
	endproperty
	a_primary_override_roles: assert property (p_primary_override_roles)
		else $error("override role 0 wrong directions");

	property p_primary_internal_sync;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		primary_port_cfg.internal_frame_sync ==
			($past(clock_role_reg[ACC_PRIMARY_INT_FS_BIT]) &&
			primary_port_cfg.frame_sync_output);
	endproperty
	a_primary_internal_sync: assert property (p_primary_internal_sync)
		else $error("primary frame sync source wrong");

	property p_secondary_sync_src;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		secondary_port_cfg.internal_frame_sync ==
			($past(clock_role_reg[ACC_SECONDARY_INT_FS_BIT]) &&
			secondary_port_cfg.frame_sync_output);
	endproperty
	a_secondary_sync_src: assert property (p_secondary_sync_src)
		else $error("secondary frame sync source wrong");

	property p_adc_custom;
		@(posedge clock) disable iff (reset)
		reg_write && reg_address == ACC_ADC_CHANNEL_OFFSET &&
			reg_write_data[ACC_FORCE_CUSTOM_BIT] ##1
			!(reg_write && reg_address == ACC_ADC_CHANNEL_OFFSET) |=>
			adc_channel_enable ==
				$past(reg_write_data[ACC_CUSTOM_MASK_LSB +: 4], 2);
	endproperty
	a_adc_custom: assert property (p_adc_custom)
		else $error("ADC custom mask not applied");

	property p_dac_select;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		dac_channel_enable == ($past(dac_channel_reg[ACC_FORCE_CUSTOM_BIT]) ?
			$past(dac_channel_reg[ACC_CUSTOM_MASK_LSB +: 4]) :
			$past(dac_max_channel_select));
	endproperty
	a_dac_select: assert property (p_dac_select)
		else $error("DAC channel limit wrong");

	property p_converter_enable;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		rate_cfg.rate_converter_enable ==
			$past(rate_enable_reg[ACC_RATE_ENABLE_BIT]) &&
			rate_cfg.autodetect_active ==
			!$past(rate_enable_reg[ACC_AUTODETECT_DIS_BIT]);
	endproperty
	a_converter_enable: assert property (p_converter_enable)
		else $error("rate converter enable or detect wrong");

	property p_main_rate;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		rate_cfg.main_rate_from_secondary |->
			!rate_cfg.main_rate_auto &&
			$past(rate_ratio_reg[ACC_MAIN_SELECT_BIT]);
	endproperty
	a_main_rate: assert property (p_main_rate)
		else $error("main rate selection wrong");

	property p_ratio_codes;
		@(posedge clock) disable iff (reset || !past_valid_reg)
		rate_cfg.ratio_m.auto_infer ==
			($past(rate_ratio_reg[ACC_RATIO_M_LSB +: 3]) == ACC_RATIO_AUTO) &&
			(rate_cfg.ratio_n.reserved ||
			rate_cfg.ratio_n.value ==
			$past(rate_ratio_reg[ACC_RATIO_N_LSB +: 3]));
	endproperty
	a_ratio_codes: assert property (p_ratio_codes)
		else $error("ratio field decode wrong");

endmodule : acc_config_regs

`default_nettype wire

// file: tb/acc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the parallel register port
module acc_host_model (
	input wire logic clock,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_address,
	output logic [7:0] reg_write_data
);

	initial
	begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_address = 8'h00;
		reg_write_data = 8'h00;
	end

	// One strobe cycle, then address and data no longer hold
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_address <= a;
		reg_write_data <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_address <= ~a;
		reg_write_data <= ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_address <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		reg_address <= ~a;
	endtask : read_reg

endmodule : acc_host_model

`default_nettype wire

// file: tb/tb_acc_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

module tb_acc_config_regs
	import acc_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic reg_write;
	logic reg_read;
	logic reg_read_valid;
	logic [7:0] reg_address;
	logic [7:0] reg_write_data;
	logic [7:0] reg_read_data;
	logic primary_role_select = 1'b0;
	logic secondary_role_select = 1'b0;
	logic [3:0] adc_max_channel_select = 4'h0;
	logic [3:0] dac_max_channel_select = 4'h0;
	acc_port_type primary_port_cfg;
	acc_port_type secondary_port_cfg;
	logic [3:0] adc_channel_enable;
	logic [3:0] dac_channel_enable;
	acc_rate_type rate_cfg;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [7:0] exp_q [$];
	logic [7:0] sh [5];
	localparam logic [7:0] AD [5] = '{ACC_CLOCK_ROLE_OFFSET,
		ACC_ADC_CHANNEL_OFFSET, ACC_DAC_CHANNEL_OFFSET,
		ACC_RATE_ENABLE_OFFSET, ACC_RATE_RATIO_OFFSET};
	localparam logic [7:0] WM [5] = '{ACC_CLOCK_ROLE_WMASK,
		ACC_CHANNEL_WMASK, ACC_CHANNEL_WMASK, ACC_RATE_ENABLE_WMASK,
		ACC_RATE_RATIO_WMASK};
	localparam logic [7:0] FM [5] = '{8'hC6, 8'hF8, 8'hF8, 8'hC0, 8'hFF};

	always #10 clock = ~clock;

	acc_host_model acc_host_model_i (.clock(clock), .reg_write(reg_write),
		.reg_read(reg_read), .reg_address(reg_address),
		.reg_write_data(reg_write_data));

	acc_config_regs acc_config_regs_i (.clock(clock), .reset(reset),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_address(reg_address), .reg_write_data(reg_write_data),
		.reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
		.primary_role_select(primary_role_select),
		.secondary_role_select(secondary_role_select),
		.adc_max_channel_select(adc_max_channel_select),
		.dac_max_channel_select(dac_max_channel_select),
		.primary_port_cfg(primary_port_cfg),
		.secondary_port_cfg(secondary_port_cfg),
		.adc_channel_enable(adc_channel_enable),
		.dac_channel_enable(dac_channel_enable), .rate_cfg(rate_cfg));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			n_mismatch++;
		end
	endtask : check

	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	function automatic acc_port_type port_exp(logic ovr, logic role,
		logic intfs);
		acc_port_type p;
		p.bit_clock_output = role;
		p.frame_sync_output = ovr ? !role : role;
		p.autodetect_available = !ovr;
		p.internal_frame_sync = p.frame_sync_output & intfs;
		return p;
	endfunction : port_exp

	function automatic acc_ratio_type ratio_exp(logic [2:0] c);
		acc_ratio_type r;
		r.auto_infer = (c == 3'h0);
		r.reserved = (c == 3'h5) || (c == 3'h7);
		r.value = (r.auto_infer || r.reserved) ? 3'h0 : c;
		return r;
	endfunction : ratio_exp

	function automatic acc_rate_type rate_exp(logic [7:0] e, logic [7:0] r);
		acc_rate_type x;
		x.rate_converter_enable = e[7];
		x.autodetect_active = !e[6];
		x.main_rate_auto = !r[7];
		x.main_rate_from_secondary = r[7] & r[6];
		x.ratio_m = ratio_exp(r[5:3]);
		x.ratio_n = ratio_exp(r[2:0]);
		return x;
	endfunction : rate_exp

	task automatic wr(input int i, input logic [7:0] d);
		acc_host_model_i.write_reg(AD[i], d);
		sh[i] = d & WM[i];
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		acc_host_model_i.read_reg(a);
	endtask : rd

	task automatic check_all();
		repeat (3) @(posedge clock);
		#1;
		check(16'(primary_port_cfg), 16'(port_exp(sh[0][7],
			primary_role_select, sh[0][2])));
		check(16'(secondary_port_cfg), 16'(port_exp(sh[0][6],
			secondary_role_select, sh[0][1])));
		check(16'(adc_channel_enable), 16'(sh[1][7] ? sh[1][6:3] :
			adc_max_channel_select));
		check(16'(dac_channel_enable), 16'(sh[2][7] ? sh[2][6:3] :
			dac_max_channel_select));
		check(16'(rate_cfg),
			16'(rate_exp(sh[3], sh[4])));
	endtask : check_all

	// Read data compared against the oldest note
	always @(posedge clock)
	begin
		if (reg_read_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(16'(reg_read_data), 16'h0100);
			else
				check(16'(reg_read_data),
					16'(exp_q.pop_front()));
		end
	end

	task automatic reset_and_read();
		sh = '{default: 8'h00};
		check_all();
		for (int i = 0; i < 5; i++)
			rd(AD[i], 8'h00);
		rd(8'h20, 8'h00);
	endtask : reset_and_read

	initial
	begin
		int k;
		logic [7:0] d;
		void'($urandom(11));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		reset_and_read();
		// All ones, read-only bits included on purpose
		for (int i = 0; i < 5; i++)
		begin
			wr(i, 8'hFF);
			rd(AD[i], sh[i]);
		end
		acc_host_model_i.write_reg(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		// Every ratio code, reserved ones too, to pin their decode
		for (int c = 0; c < 8; c++)
		begin
			wr(4, {c[0], c[1], c[2:0], 3'(7 - c)});
			check_all();
		end
		repeat (40)
		begin
			k = $urandom_range(4, 0);
			@(posedge clock);
			primary_role_select <= 1'($urandom);
			secondary_role_select <= 1'($urandom);
			adc_max_channel_select <= 4'($urandom);
			dac_max_channel_select <= 4'($urandom);
			d = 8'($urandom) & FM[k];
			if (k == 4 && d[5] && d[3])
				d[3] = 1'b0;
			if (k == 4 && d[2] && d[0])
				d[0] = 1'b0;
			wr(k, d);
			check_all();
			rd(AD[k], sh[k]);
		end
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check(16'(rate_cfg), 16'h0000);
		check(16'(primary_port_cfg), 16'h0000);
		@(posedge clock);
		reset <= 1'b0;
		reset_and_read();
		repeat (4) @(posedge clock);
		summarize();
	end

	initial
	begin
		#200_000;
		n_mismatch++;
		summarize();
	end

endmodule : tb_acc_config_regs

`default_nettype wire
